// >>> design/acrb_defs.svh
// Constants for the audio clock, rate and bank control pair.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef ACRB_DEFS_SVH
`define ACRB_DEFS_SVH
`define ACRB_CLK_MHZ        250
`define ACRB_SETTLE_US      5000
`define ACRB_SETTLE_CYC     (`ACRB_SETTLE_US * `ACRB_CLK_MHZ)
`define ACRB_DRIFT_MAX      12'h00A
// Register byte offsets
`define ACRB_OFF_MODLIM     16'h0016
`define ACRB_OFF_BANKCTL    16'h0040
`define ACRB_OFF_RATEMODE   16'h00C5
`define ACRB_OFF_CLKCTL     16'h0050
`define ACRB_OFF_STATUS     16'h0054
`define ACRB_OFF_BANKWIN    16'h1000
// Reset values
`define ACRB_RST_MODLIM     8'hF0
`define ACRB_RST_BANKCTL    32'h0000_FF00
`define ACRB_RST_RATEMODE   32'h0000_0000
`define ACRB_RST_CLKCTL     32'h0000_0001
// Field positions
`define ACRB_BANK_SEL_LSB   16
`define ACRB_BANK_M1_LSB    8
`define ACRB_BANK_M2_LSB    0
`define ACRB_RM_OUTINT_BIT  20
`define ACRB_CC_AUTO_BIT    0
`define ACRB_CC_AM_BIT      1
`define ACRB_CC_RATIO_LSB   4
`define ACRB_CC_RATE_LSB    8
// Frame period thresholds in system clocks, 250 MHz base
`define ACRB_PER_32K        16'd6740
`define ACRB_PER_44K        16'd5438
`define ACRB_PER_48K        16'd3900
`define ACRB_PER_88K        16'd2719
`define ACRB_PER_96K        16'd2010
`define ACRB_PER_176K       16'd1360
`endif

// >>> design/acrb_pkg.sv
// Types used by the device end of the audio clock link.
// Constants live in acrb_defs.svh.
package acrb_pkg;
  typedef enum logic [3:0] {
    SEQ_RUN    = 4'b0001,
    SEQ_MUTE   = 4'b0010,
    SEQ_UPDATE = 4'b0100,
    SEQ_SETTLE = 4'b1000
  } seq_t;
  // Data rate codes: 32, 44.1, 48, 88.2, 96, 176.4, 192 kHz
  typedef logic [2:0] rate_t;
  // Ratio codes: 64, 128, 196, 256, 384, 512, 768 times fs
  typedef logic [2:0] ratio_t;
endpackage

// >>> design/acrb_link_if.sv
// Serial audio clock link between the source and the device.
// Plain single-driver wires; the source drives all three.
`timescale 1ns/1ns
interface acrb_link_if;
  logic mclk;
  logic sclk;
  logic lrclk;
  modport src (output mclk, output sclk, output lrclk);
  modport dev (input mclk, input sclk, input lrclk);
endinterface

// >>> design/acrb_source.sv
// Source end: makes master, bit and frame clocks from clk_i.
// Assumes run_i and settings are held steady while running.
`timescale 1ns/1ns
`include "acrb_defs.svh"
module acrb_source #(
  parameter int RATIO_W = 10
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               run_i,
  input  wire logic [RATIO_W-1:0] ratio_i,
  input  wire logic [7:0]         mclk_half_i,
  acrb_link_if.src                link
);
  initial begin
    if (RATIO_W < 10) $error("RATIO_W too small for 768");
  end

  typedef struct packed {
    logic [7:0]         hc;
    logic               mclk;
    logic [RATIO_W-1:0] mc;
    logic [RATIO_W-1:0] sc;
  } st_t;

  st_t st_ff;
  st_t nxt_st;
  logic [RATIO_W-1:0] per;

  // Bit clock period in master clocks
  assign per = ratio_i >> 6;

  // Master clock divider and frame count
  always_comb begin
    nxt_st = st_ff;
    if (!run_i) begin
      nxt_st = '0;
    end else if (st_ff.hc >= mclk_half_i) begin
      nxt_st.hc   = 8'h00;
      nxt_st.mclk = ~st_ff.mclk;
      if (st_ff.mclk) begin
        nxt_st.mc = (st_ff.mc + 1'b1 >= ratio_i) ? '0 : st_ff.mc + 1'b1;
        nxt_st.sc = (st_ff.sc + 1'b1 >= per || st_ff.mc + 1'b1 >= ratio_i)
                    ? '0 : st_ff.sc + 1'b1;
      end
    end else begin
      nxt_st.hc = st_ff.hc + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.mclk  = st_ff.mclk;
  assign link.sclk  = run_i && ((per <= 1) ? st_ff.mclk
                                           : (st_ff.sc < (per >> 1)));
  assign link.lrclk = run_i && (st_ff.mc < (ratio_i >> 1));
endmodule

// >>> design/acrb_device.sv
// Device end: clock detection, rate control, mute sequence,
// PWM limit and coefficient banks behind a classic Wishbone slave.
// Assumes link clocks are asynchronous pins and clk_i is the
// device's own oscillator time base.
// Behaviour
// - PWM duty linear, half scale at zero
// - Modulation clamped to programmable limit
// - Internal rate double or quad speed
// - Master ratio and data rate auto-detected
// - Source keeps link clocks master-synchronous
// - Bit clock 64x, frame once per sample; source gives 65 bit clocks per frame at ratio 196
// - Drift beyond ten masters flags, resyncs
// - Host sets ratio, AM mode, rate
// - Converter output defaults to 96 kHz
// - Rate mode bit 20, bits 1:0
// - Integer master divider; fractional unsupported
// - Source gives enough master clock
// - Master-edge PWM, system-clock control
// - Oscillator time base for detection
// - Registers work without master clock
// - Ratio detection only when auto enabled
// - Ratio change: mute, update, settle, unmute
// - Three banks, manual or auto
// - Each bank holds full coefficient set
// - Reset: manual bank one, all three banks zeroed
// - Host programs banks two, three first
// - 192 kHz content uses 96 kHz bank
`timescale 1ns/1ns
`include "acrb_defs.svh"
module acrb_device #(
  parameter int BANK_AW    = 9,
  parameter int SETTLE_CYC = `ACRB_SETTLE_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  acrb_link_if.dev                link,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [15:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [15:0]        sample_i,
  input  wire logic [BANK_AW-1:0] coef_adr_i,
  output logic      [31:0]        coef_dat_o,
  output logic                    pwm_o,
  output logic                    mute_o,
  output logic                    clk_err_o,
  output logic                    div_en_o,
  output logic                    unsupported_o
);
  initial begin
    if (BANK_AW < 9) $error("BANK_AW cannot hold 295 words");
    if (SETTLE_CYC < 1) $error("SETTLE_CYC must be positive");
  end

  typedef struct packed {
    logic [2:0]         s1, s2, s3;
    logic [11:0]        mcnt, sph, ref_mpf, ref_sph;
    logic               sph_got, synced, err;
    logic [15:0]        per;
    acrb_pkg::ratio_t   ratio, det_ratio;
    acrb_pkg::rate_t    rate;
    acrb_pkg::seq_t     seq;
    logic [22:0]        tmr;
    logic [10:0]        dcnt;
    logic               div_en;
    logic [7:0]         pcnt, modlim;
    logic               pwm;
    logic [31:0]        bankctl, ratemode, clkctl, rdat;
    logic [1:0]         bank;
    logic               ack, clr;
    logic [BANK_AW+1:0] cptr;
  } st_t;

  st_t st_ff;
  st_t nxt_st;
  logic [31:0] mem [0:3*(2**BANK_AW)-1];
  logic [31:0] mem_rd;
  logic [31:0] coef_ff;
  logic        mem_we;
  logic [BANK_AW+1:0] mem_wa;
  logic [2:0]  rise;
  logic        req;
  logic [2:0]  bsel;
  logic [1:0]  wbank;
  logic [20:0] num;
  logic [17:0] den;
  logic [10:0] div;
  logic [11:0] dmpf, dsph;
  logic [7:0]  duty;
  logic [31:0] wmask;
  logic [2:0]  mbit;

  // Ratio code to master clocks per frame
  function automatic logic [9:0] ratio_mult(input logic [2:0] c);
    case (c)
      3'h0: ratio_mult = 10'd64;
      3'h1: ratio_mult = 10'd128;
      3'h2: ratio_mult = 10'd196;
      3'h3: ratio_mult = 10'd256;
      3'h4: ratio_mult = 10'd384;
      3'h5: ratio_mult = 10'd512;
      default: ratio_mult = 10'd768;
    endcase
  endfunction

  // Rate code to kHz times ten
  function automatic logic [10:0] rate_x10(input logic [2:0] c);
    case (c)
      3'h0: rate_x10 = 11'd320;
      3'h1: rate_x10 = 11'd441;
      3'h2: rate_x10 = 11'd480;
      3'h3: rate_x10 = 11'd882;
      3'h4: rate_x10 = 11'd960;
      3'h5: rate_x10 = 11'd1764;
      default: rate_x10 = 11'd1920;
    endcase
  endfunction

  assign rise  = st_ff.s2 & ~st_ff.s3;
  assign req   = wb_cyc_i && wb_stb_i && !st_ff.ack && !st_ff.clr;
  assign bsel  = st_ff.bankctl[`ACRB_BANK_SEL_LSB +: 3];
  // Bank set mode writes its own bank, else the active one
  assign wbank = (bsel >= 3'h4) ? 2'(bsel - 3'h4) : st_ff.bank;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign dmpf  = (st_ff.mcnt > st_ff.ref_mpf) ? st_ff.mcnt - st_ff.ref_mpf
                                              : st_ff.ref_mpf - st_ff.mcnt;
  assign dsph  = (st_ff.sph > st_ff.ref_sph) ? st_ff.sph - st_ff.ref_sph
                                             : st_ff.ref_sph - st_ff.sph;
  // integer divide to 64x internal rate
  // 96 kHz or 192 kHz internal rate
  // quad only when mode bits read 01
  assign num = 21'(ratio_mult(st_ff.ratio)) * 21'(rate_x10(st_ff.rate));
  assign den = (st_ff.ratemode[1:0] == 2'b01) ? 18'd122880 : 18'd61440;
  assign div = 11'(num / den);
  // 192 kHz content maps to the 96 kHz mask bit
  assign mbit = (st_ff.rate == 3'h6) ? 3'h4 : st_ff.rate;

  // offset binary duty, 0x80 at zero
  // clamp between limit and its mirror
  always_comb begin
    duty = {~sample_i[15], sample_i[14:8]};
    if (st_ff.seq != acrb_pkg::SEQ_RUN) begin
      duty = 8'h80;
    end else if (duty > st_ff.modlim) begin
      duty = st_ff.modlim;
    end else if (duty < ~st_ff.modlim) begin
      duty = ~st_ff.modlim;
    end
  end

  // Whole control state next value
  always_comb begin
    nxt_st     = st_ff;
    mem_we     = 1'b0;
    mem_wa     = {wbank, wb_adr_i[BANK_AW+1:2]};
    nxt_st.s1  = {link.mclk, link.sclk, link.lrclk};
    nxt_st.s2  = st_ff.s1;
    nxt_st.s3  = st_ff.s2;
    nxt_st.ack = req;
    nxt_st.per = (st_ff.per == 16'hFFFF) ? st_ff.per : st_ff.per + 16'h1;
    nxt_st.div_en = 1'b0;
    // Clock error is a one-cycle pulse
    nxt_st.err    = 1'b0;
    // frame period measured in oscillator cycles
    if (rise[2]) begin
      nxt_st.mcnt = st_ff.mcnt + 12'h1;
      if (!st_ff.sph_got && rise[1]) nxt_st.sph = st_ff.mcnt;
      // internal 64x enable every div masters
      if (st_ff.dcnt + 11'h1 >= div) begin
        nxt_st.dcnt   = 11'h0;
        nxt_st.div_en = !unsupported_o;
      end else begin
        nxt_st.dcnt = st_ff.dcnt + 11'h1;
      end
      // PWM advances on master clock edges
      nxt_st.pcnt = st_ff.pcnt + 8'h01;
      nxt_st.pwm  = (st_ff.pcnt < duty);
    end
    if (rise[1] && !rise[0]) nxt_st.sph_got = 1'b1;
    if (rise[0]) begin
      nxt_st.mcnt    = 12'h0;
      nxt_st.per     = 16'h0;
      nxt_st.sph_got = 1'b0;
      nxt_st.synced  = 1'b1;
      nxt_st.err     = 1'b0;
      if (!st_ff.synced || dmpf > `ACRB_DRIFT_MAX
          || dsph > `ACRB_DRIFT_MAX) begin
        nxt_st.ref_mpf = st_ff.mcnt;
        nxt_st.ref_sph = st_ff.sph;
        nxt_st.err     = st_ff.synced;
      end
      // classify ratio from masters per frame
      if      (st_ff.mcnt < 12'd96)  nxt_st.det_ratio = 3'h0;
      else if (st_ff.mcnt < 12'd162) nxt_st.det_ratio = 3'h1;
      else if (st_ff.mcnt < 12'd226) nxt_st.det_ratio = 3'h2;
      else if (st_ff.mcnt < 12'd320) nxt_st.det_ratio = 3'h3;
      else if (st_ff.mcnt < 12'd448) nxt_st.det_ratio = 3'h4;
      else if (st_ff.mcnt < 12'd640) nxt_st.det_ratio = 3'h5;
      else                           nxt_st.det_ratio = 3'h6;
      // classify data rate from frame period
      if (st_ff.clkctl[`ACRB_CC_AUTO_BIT]) begin
        if      (st_ff.per > `ACRB_PER_32K)  nxt_st.rate = 3'h0;
        else if (st_ff.per > `ACRB_PER_44K)  nxt_st.rate = 3'h1;
        else if (st_ff.per > `ACRB_PER_48K)  nxt_st.rate = 3'h2;
        else if (st_ff.per > `ACRB_PER_88K)  nxt_st.rate = 3'h3;
        else if (st_ff.per > `ACRB_PER_96K)  nxt_st.rate = 3'h4;
        else if (st_ff.per > `ACRB_PER_176K) nxt_st.rate = 3'h5;
        else                                 nxt_st.rate = 3'h6;
      end
    end
    case (st_ff.seq)
      acrb_pkg::SEQ_RUN: begin
        // detection acts only with auto enabled
        if (st_ff.clkctl[`ACRB_CC_AUTO_BIT] && st_ff.synced
            && st_ff.det_ratio != st_ff.ratio) begin
          nxt_st.seq = acrb_pkg::SEQ_MUTE;
        end
      end
      acrb_pkg::SEQ_MUTE: begin
        nxt_st.seq = acrb_pkg::SEQ_UPDATE;
      end
      acrb_pkg::SEQ_UPDATE: begin
        nxt_st.ratio = st_ff.det_ratio;
        nxt_st.clkctl[`ACRB_CC_RATIO_LSB +: 3] = st_ff.det_ratio;
        // auto bank picks first matching mask
        if (bsel == 3'h3) begin
          if (st_ff.bankctl[`ACRB_BANK_M1_LSB + mbit]) nxt_st.bank = 2'h0;
          else if (st_ff.bankctl[`ACRB_BANK_M2_LSB + mbit])
            nxt_st.bank = 2'h1;
          else nxt_st.bank = 2'h2;
        end
        nxt_st.tmr = '0;
        nxt_st.seq = acrb_pkg::SEQ_SETTLE;
      end
      acrb_pkg::SEQ_SETTLE: begin
        nxt_st.tmr = st_ff.tmr + 23'h1;
        if (st_ff.tmr >= 23'(SETTLE_CYC - 1)) nxt_st.seq = acrb_pkg::SEQ_RUN;
      end
      default: nxt_st.seq = acrb_pkg::SEQ_RUN;
    endcase
    // sweep banks to zero after reset
    if (st_ff.clr) begin
      mem_we      = 1'b1;
      mem_wa      = st_ff.cptr;
      nxt_st.cptr = st_ff.cptr + 1'b1;
      if (st_ff.cptr == (BANK_AW+2)'(3*(2**BANK_AW)-1)) nxt_st.clr = 1'b0;
    end
    // register access runs on clk_i alone
    if (req && wb_we_i) begin
      if (wb_adr_i == `ACRB_OFF_MODLIM) begin
        if (wb_sel_i[0]) nxt_st.modlim = wb_dat_i[7:0];
      end else if (wb_adr_i == `ACRB_OFF_BANKCTL) begin
        nxt_st.bankctl = (st_ff.bankctl & ~wmask) | (wb_dat_i & wmask);
        if (wb_sel_i[2] && wb_dat_i[18:16] < 3'h3)
          nxt_st.bank = wb_dat_i[17:16];
      end else if (wb_adr_i == `ACRB_OFF_RATEMODE) begin
        // bit 20 and rate bits 1:0
        nxt_st.ratemode = (st_ff.ratemode & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == `ACRB_OFF_CLKCTL) begin
        // ratio, AM mode and rate by hand
        nxt_st.clkctl = (st_ff.clkctl & ~wmask) | (wb_dat_i & wmask);
        if (wb_sel_i[0]) nxt_st.ratio = wb_dat_i[6:4];
        if (wb_sel_i[1]) nxt_st.rate  = wb_dat_i[10:8];
      end else if (wb_adr_i >= `ACRB_OFF_BANKWIN) begin
        mem_we = 1'b1;
      end
    end
    nxt_st.clkctl[`ACRB_CC_RATE_LSB +: 3] = nxt_st.rate;
    // ratio field mirrors the ratio in use
    nxt_st.clkctl[`ACRB_CC_RATIO_LSB +: 3] = nxt_st.ratio;
    // Read data, unmapped reads zero
    if      (wb_adr_i == `ACRB_OFF_MODLIM)   nxt_st.rdat = {24'h0, st_ff.modlim};
    else if (wb_adr_i == `ACRB_OFF_BANKCTL)  nxt_st.rdat = st_ff.bankctl;
    else if (wb_adr_i == `ACRB_OFF_RATEMODE) nxt_st.rdat = st_ff.ratemode;
    else if (wb_adr_i == `ACRB_OFF_CLKCTL)   nxt_st.rdat = st_ff.clkctl;
    else if (wb_adr_i == `ACRB_OFF_STATUS)
      nxt_st.rdat = {22'h0, st_ff.seq, st_ff.bank, unsupported_o,
                     st_ff.err, st_ff.synced, mute_o};
    else if (wb_adr_i >= `ACRB_OFF_BANKWIN)  nxt_st.rdat = mem_rd;
    else                                     nxt_st.rdat = 32'h0;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff          <= '0;
      st_ff.seq      <= acrb_pkg::SEQ_RUN;
      st_ff.modlim   <= `ACRB_RST_MODLIM;
      st_ff.bankctl  <= `ACRB_RST_BANKCTL;
      st_ff.ratemode <= `ACRB_RST_RATEMODE;
      st_ff.clkctl   <= `ACRB_RST_CLKCTL;
      st_ff.ratio    <= 3'h3;
      st_ff.det_ratio <= 3'h3;
      st_ff.rate     <= 3'h4;
      st_ff.clr      <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Coefficient memory, three banks
  always_ff @(posedge clk_i) begin
    if (mem_we) mem[mem_wa] <= st_ff.clr ? 32'h0 : wb_dat_i;
    coef_ff <= mem[{st_ff.bank, coef_adr_i}];
  end
  assign mem_rd = mem[{wbank, wb_adr_i[BANK_AW+1:2]}];

  assign wb_ack_o      = st_ff.ack;
  assign wb_dat_o      = st_ff.rdat;
  assign coef_dat_o    = coef_ff;
  assign pwm_o         = st_ff.pwm;
  assign mute_o        = (st_ff.seq != acrb_pkg::SEQ_RUN);
  assign clk_err_o     = st_ff.err;
  assign div_en_o      = st_ff.div_en;
  assign unsupported_o = (div == 11'h0) || ((num % den) != 21'h0);
endmodule

// >>> verif/acrb_sva.sv
// Checker for the audio clock link and the device's outputs.
// Instantiated beside the link interface; one clock domain.
`timescale 1ns/1ns
module acrb_sva #(
  parameter int RATIO_W    = 10,
  parameter int SETTLE_CYC = 50
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               mclk,
  input wire logic               sclk,
  input wire logic               lrclk,
  input wire logic               run_i,
  input wire logic [RATIO_W-1:0] ratio_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire logic               mute_o,
  input wire logic               clk_err_o,
  input wire logic               div_en_o
);
  typedef struct packed {
    logic [15:0] mlen;
    logic [10:0] mcnt;
    logic [10:0] scnt;
    logic        seen;
    logic [2:0]  q;
  } chk_st_t;
  chk_st_t     st_ff;
  chk_st_t     nxt_st;
  logic        mr;
  logic        sr;
  logic        lr;
  logic [10:0] mtot;
  logic [10:0] stot;
  // Edges seen this cycle and totals of the frame ending now
  assign mr = mclk & ~st_ff.q[2];
  assign sr = sclk & ~st_ff.q[1];
  assign lr = lrclk & ~st_ff.q[0];
  assign mtot = st_ff.mcnt + 11'(mr);
  assign stot = st_ff.scnt + 11'(sr);
  // Mute length and edges per frame
  always_comb begin
    nxt_st = st_ff;
    nxt_st.q = {mclk, sclk, lrclk};
    nxt_st.mlen = mute_o ? st_ff.mlen + 16'h0001 : 16'h0000;
    nxt_st.mcnt = lr ? 11'h000 : mtot;
    nxt_st.scnt = lr ? 11'h000 : stot;
    if (!run_i) nxt_st.seen = 1'b0;
    else if (lr) nxt_st.seen = 1'b1;
  end
  // Register the helper state
  always_ff @(posedge clk_i) begin
    if (rst_i) st_ff <= '0;
    else st_ff <= nxt_st;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i; endsequence
  sequence s_frame; lr && st_ff.seen && run_i; endsequence
  property p_ack_pulse; s_req ##0 wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i) && wb_cyc_i && wb_stb_i;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  property p_mclk_frame; s_frame |-> mtot == 11'(ratio_i); endproperty
  a_mclk_frame: assert property (p_mclk_frame)
    else $error("master clocks per frame differ from ratio");
  property p_sclk_frame;
    s_frame ##0 (ratio_i[5:0] == 6'h00) |-> stot == 11'h040;
  endproperty
  a_sclk_frame: assert property (p_sclk_frame)
    else $error("bit clocks per frame not 64");
  property p_idle; !run_i [*3] |-> !mclk && !sclk && !lrclk; endproperty
  a_idle: assert property (p_idle)
    else $error("link clocks active while stopped");
  property p_mute_min; $fell(mute_o) |-> st_ff.mlen >= SETTLE_CYC; endproperty
  a_mute_min: assert property (p_mute_min)
    else $error("unmute before settle time");
  property p_mute_max; mute_o |-> st_ff.mlen <= SETTLE_CYC + 8; endproperty
  a_mute_max: assert property (p_mute_max)
    else $error("mute held past settle time");
  property p_err; clk_err_o |=> !clk_err_o; endproperty
  a_err: assert property (p_err)
    else $error("clock error flag longer than one cycle");
  property p_div; div_en_o |=> !div_en_o; endproperty
  a_div: assert property (p_div)
    else $error("divider enable longer than one cycle");
endmodule

// >>> verif/audio_clock_rate_bank_control_test.sv
// Self-checking bench: source and device face each other over the link.
// Registers reached over classic Wishbone; settle time shortened.
`timescale 1ns/1ns
module audio_clock_rate_bank_control_test;
  localparam int SETTLE = 50;
  logic        clk_i, rst_i, run_i, cyc, stb, we;
  logic [9:0]  ratio_i;
  logic [7:0]  half, lim;
  logic [15:0] adr, sample, s;
  logic [31:0] wdat, q, v, w, wb_dat_o, coef_dat_o;
  logic [8:0]  cadr, nw;
  logic [3:0]  sel;
  logic        wb_ack_o, pwm_o, mute_o, clk_err_o, div_en_o, unsup;
  int          n_fail, checks_done, k;
  int          rv[7] = '{64, 128, 196, 256, 384, 512, 768};
  int          ord[7] = '{0, 1, 2, 4, 5, 6, 3};
  acrb_link_if link ();
  acrb_source u_acrb_source (.clk_i(clk_i), .rst_i(rst_i), .run_i(run_i),
    .ratio_i(ratio_i), .mclk_half_i(half), .link(link));
  acrb_device #(.SETTLE_CYC(SETTLE)) u_acrb_device (.clk_i(clk_i),
    .rst_i(rst_i), .link(link), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_i(sample),
    .coef_adr_i(cadr), .coef_dat_o(coef_dat_o), .pwm_o(pwm_o),
    .mute_o(mute_o), .clk_err_o(clk_err_o), .div_en_o(div_en_o),
    .unsupported_o(unsup));
  acrb_sva #(.RATIO_W(10), .SETTLE_CYC(SETTLE)) u_acrb_sva (.clk_i(clk_i),
    .rst_i(rst_i), .mclk(link.mclk), .sclk(link.sclk), .lrclk(link.lrclk),
    .run_i(run_i), .ratio_i(ratio_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(wb_ack_o), .mute_o(mute_o), .clk_err_o(clk_err_o),
    .div_en_o(div_en_o));
  // System clock, 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Value comparison, also used for flags
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  // One classic Wishbone cycle; read data lands in q
  task automatic wb(input logic wr, input logic [15:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 4000);
    if (n >= 4000) chk_flag(1'b0, 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk_val(q, e);
  endtask
  task automatic coef_chk(input logic [8:0] n, input logic [31:0] e);
    cadr <= n;
    repeat (3) @(posedge clk_i);
    chk_val(coef_dat_o, e);
  endtask
  // Stop the source, change its settings, start it again
  task automatic restart(input logic [9:0] r, input logic [7:0] h);
    @(posedge clk_i);
    run_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    ratio_i <= r;
    half <= h;
    @(posedge clk_i);
    run_i <= 1'b1;
  endtask
  task automatic wait_mute(input logic lvl, input int lim_cyc);
    int n;
    n = 0;
    while (mute_o !== lvl && n < lim_cyc) begin
      @(posedge clk_i);
      n++;
    end
    chk_flag(mute_o, lvl);
  endtask
  // Offset-binary duty clamped to the modulation limit
  function automatic logic [7:0] exp_duty(input logic [15:0] x,
                                          input logic [7:0] l);
    logic [7:0] t;
    t = x[15:8] ^ 8'h80;
    if (t > l) t = l;
    if (t < ~l) t = ~l;
    return t;
  endfunction
  // High cycles over 256 steps of four system clocks each
  task automatic pwm_chk(input logic [7:0] d);
    int c;
    c = 0;
    repeat (1024) begin
      @(posedge clk_i);
      if (pwm_o === 1'b1) c++;
    end
    chk_val(32'(c), {22'h0, d, 2'b00});
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog about twice the expected run length of 45000 cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    chk_flag(1'b0, 1'b1);
    end_of_test();
  end
  // Main sequence
  initial begin
    n_fail = 0;
    checks_done = 0;
    {rst_i, run_i, cyc, stb, we, sel} = {5'b10000, 4'h0};
    {adr, wdat, sample, cadr, half} = '0;
    ratio_i = 10'd256;
    void'($urandom(32'h73b2042a));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(16'h0016, 32'h0000_00F0);
    rd_chk(16'h0040, 32'h0000_FF00);
    rd_chk(16'h00C5, 32'h0000_0000);
    rd_chk(16'h0050, 32'h0000_0431);
    rd_chk(16'h0200, 32'h0000_0000);
    chk_flag(unsup, 1'b0);
    for (int i = 0; i < 7; i++) begin
      v = {13'h0, 3'(i), 16'($urandom)};
      wb(1'b1, 16'h0040, v);
      rd_chk(16'h0040, v);
    end
    v = {24'h0, 8'($urandom)};
    wb(1'b1, 16'h0016, v);
    rd_chk(16'h0016, v);
    wb(1'b1, 16'h00C5, 32'h0010_0001);
    rd_chk(16'h00C5, 32'h0010_0001);
    wb(1'b1, 16'h00C5, 32'h0000_0000);
    $display("test registers done");
    nw = 9'($urandom);
    v = $urandom;
    w = $urandom;
    wb(1'b1, 16'h0040, 32'h0000_FF00);
    wb(1'b1, 16'h1000 + {5'h0, nw, 2'b00}, v);
    wb(1'b1, 16'h0040, 32'h0005_FF00);
    wb(1'b1, 16'h1000 + {5'h0, nw, 2'b00}, w);
    coef_chk(nw, v);
    wb(1'b1, 16'h0040, 32'h0001_FF00);
    coef_chk(nw, w);
    wb(1'b1, 16'h0040, 32'h0002_FF00);
    coef_chk(nw, 32'h0);
    wb(1'b1, 16'h0040, 32'h0000_FF00);
    coef_chk(nw, v);
    $display("test banks done");
    for (int i = 0; i < 7; i++) begin
      restart(10'(rv[ord[i]]), 8'h00);
      wait_mute(1'b1, 20000);
      // A cut frame may mute once early; let full frames settle it
      repeat (6 * rv[ord[i]]) @(posedge clk_i);
      wait_mute(1'b0, 2000);
      wb(1'b0, 16'h0050, 32'h0);
      chk_val({29'h0, q[6:4]}, 32'(ord[i]));
    end
    $display("test ratio detect done");
    restart(10'd256, 8'h01);
    for (int i = 0; i < 4; i++) begin
      lim = (i < 2) ? 8'hF0 : 8'hC0;
      s = (i == 0) ? 16'h0000 : (i == 1) ? 16'h7FFF : 16'($urandom);
      if (i == 2) s = 16'h8000;
      wb(1'b1, 16'h0016, {24'h0, lim});
      sample <= s;
      repeat (2100) @(posedge clk_i);
      chk_flag(mute_o, 1'b0);
      pwm_chk(exp_duty(s, lim));
    end
    $display("test pwm done");
    wb(1'b1, 16'h0050, 32'h0000_0422);
    repeat (200) @(posedge clk_i);
    restart(10'd768, 8'h00);
    k = 0;
    repeat (8000) begin
      @(posedge clk_i);
      if (mute_o === 1'b1) k++;
    end
    chk_val(32'(k), 32'h0);
    wb(1'b0, 16'h0050, 32'h0);
    chk_val(q & 32'h0000_0073, 32'h0000_0022);
    chk_flag(unsup, 1'b1);
    $display("test manual clock control done");
    end_of_test();
  end
endmodule
